//--- rtl/packet_transmit_control.sv
`timescale 1ns/1ps
// How it works
// - Setting transmit request starts the frame
// - Transmit waits for a running DMA
// - DMA start held off while request set
// - Clearing transmit request aborts the frame
// - At end: write status, clear request, flag
// - Start and end pointers never changed
// - Abort and late collision shown in status
// - Status fields stored low byte first
// - Status bits 55-52 and 31 zero
// - VLAN, backpressure, pause, control frame bits
// - Wire byte total and frame byte count
// - Collision count of successful frames only
// - Giant, late and excess collision bits
// - Excessive defer and single defer bits
// - Broadcast, multicast and done bits
// - Length range, length check, CRC bits
// - Per-packet choice: append CRC or check
module packet_transmit_control (
  // Clocks, reset, enable
  input wire logic core_clk_i,
  input wire logic link_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // Register port
  input wire logic [4:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Buffer memory port, read data one cycle after request
  output logic mem_rd_o,
  output logic mem_we_o,
  output logic [12:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  input wire logic [7:0] mem_rdata_i,
  // DMA engine
  output logic dma_start_o,
  input wire logic dma_done_i,
  // MAC back-off and defer logic
  input wire logic coll_late_i,
  input wire logic coll_excess_i,
  input wire logic defer_excess_i,
  input wire logic defer_once_i,
  input wire logic backpressure_i,
  input wire logic [3:0] coll_count_i,
  // Interrupt
  output logic irq_o,
  // Link side
  output logic tx_en_o,
  output logic tx_strobe_o,
  output logic [7:0] tx_byte_o
);
  import tx_ctl_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_ARB, S_RD, S_LAT, S_CAP, S_SEND, S_FCS, S_TERM, S_STAT, S_END
  } tx_state_t;

  tx_state_t state;
  logic [7:0] irq_enable_bits, irq_flag_bits, main_other;
  logic tx_request, dma_kickoff, dma_running;
  logic tx_abort_flag, late_collision_flag;
  logic [12:0] tx_start_pointer, tx_end_pointer, rd_addr;
  logic [7:0] mac_cfg [ADDR_MAC_FLOW:ADDR_MAX_LEN_HIGH];
  logic [7:0] pp_ctl;
  logic [15:0] pos, type_field, opcode;
  logic [31:0] crc, crc_next;
  logic first, in_fcs, bcast, mcast;
  logic aborted, late, excess, giant;
  logic ev_defer_once, ev_defer_excess, ev_backpressure;
  logic [3:0] coll_cnt;
  logic [1:0] fcs_idx;
  logic [2:0] stat_idx;
  logic [9:0] hand_word;
  logic req_tgl, ack_core, ack_tgl, req_link, link_rst, end_pending;

  logic wr_en, wr_main, wr_flag, crc_append, huge_ok, giant_hit, tx_fin;
  logic abort_now, busy;
  logic [15:0] max_len, payload_len;
  logic [55:0] stat_vec;
  logic [7:0] next_flags;

  assign wr_en = ce_i & reg_wr_i;
  assign wr_main = wr_en & (reg_addr_i == ADDR_MAIN_CONTROL);
  assign wr_flag = wr_en & (reg_addr_i == ADDR_IRQ_FLAG);
  assign max_len = {mac_cfg[ADDR_MAX_LEN_HIGH], mac_cfg[ADDR_MAX_LEN_LOW]};
  assign crc_append = pp_ctl[PP_OVERRIDE] ? pp_ctl[PP_CRC_EN]
                    : mac_cfg[ADDR_FRAME_CFG][FC_CRC_EN];
  assign huge_ok = pp_ctl[PP_OVERRIDE] ? pp_ctl[PP_HUGE_EN]
                 : mac_cfg[ADDR_FRAME_CFG][FC_HUGE_EN];
  assign giant_hit = !huge_ok && !first && (pos == max_len);
  assign abort_now = !tx_request || coll_late_i || coll_excess_i;
  assign busy = (state != S_IDLE) && (state != S_STAT) && (state != S_END);
  assign tx_fin = ce_i && (state == S_END);
  assign payload_len = 16'(pos - HDR_FCS_LEN);

  crc32_step u_crc (
    .crc_i(crc),
    .data_i(mem_rdata_i),
    .crc_o(crc_next)
  );

  // Host set wins over the hardware clear
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      tx_request <= 1'b0;
      dma_kickoff <= 1'b0;
      main_other <= REG_RST;
    end else if (ce_i) begin
      if (wr_main) begin
        tx_request <= reg_wdata_i[MC_TX_REQUEST];
        dma_kickoff <= reg_wdata_i[MC_DMA_KICKOFF];
        main_other <= reg_wdata_i;
      end else begin
        if (tx_fin) tx_request <= 1'b0;
        if (dma_done_i) dma_kickoff <= 1'b0;
      end
    end
  end

  // DMA may only begin while no frame is requested
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      dma_start_o <= 1'b0;
      dma_running <= 1'b0;
    end else if (ce_i) begin
      dma_start_o <= dma_kickoff && !tx_request && !dma_running
                     && !dma_start_o && (state == S_IDLE);
      if (dma_start_o) dma_running <= 1'b1;
      else if (dma_done_i) dma_running <= 1'b0;
    end
  end

  always_comb begin
    next_flags = wr_flag ? (reg_wdata_i & FLAG_MASK) : irq_flag_bits;
    if (tx_fin) next_flags[IF_TX_DONE] = 1'b1;
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      irq_enable_bits <= REG_RST;
      irq_flag_bits <= REG_RST;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      if (wr_en && reg_addr_i == ADDR_IRQ_ENABLE) irq_enable_bits <= reg_wdata_i;
      irq_flag_bits <= next_flags;
      irq_o <= irq_enable_bits[IE_GLOBAL]
               && |(irq_enable_bits[6:0] & irq_flag_bits[6:0]);
    end
  end

  // Only the host writes the pointers
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      tx_start_pointer <= PTR_RST;
      tx_end_pointer <= PTR_RST;
    end else if (wr_en) begin
      unique case (reg_addr_i)
        ADDR_TX_START_LOW: tx_start_pointer[7:0] <= reg_wdata_i;
        ADDR_TX_START_HIGH: tx_start_pointer[12:8] <= reg_wdata_i[4:0];
        ADDR_TX_END_LOW: tx_end_pointer[7:0] <= reg_wdata_i;
        ADDR_TX_END_HIGH: tx_end_pointer[12:8] <= reg_wdata_i[4:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      for (int i = ADDR_MAC_FLOW; i <= ADDR_MAX_LEN_HIGH; i++) begin
        mac_cfg[i] <= REG_RST;
      end
      mac_cfg[ADDR_MAX_LEN_LOW] <= MAX_LEN_LOW_RST;
      mac_cfg[ADDR_MAX_LEN_HIGH] <= MAX_LEN_HIGH_RST;
    end else if (wr_en && reg_addr_i >= ADDR_MAC_FLOW
                 && reg_addr_i <= ADDR_MAX_LEN_HIGH) begin
      mac_cfg[reg_addr_i] <= reg_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= REG_RST;
    end else if (ce_i) begin
      reg_rdata_o <= REG_RST;
      unique case (reg_addr_i)
        ADDR_IRQ_ENABLE: reg_rdata_o <= irq_enable_bits;
        ADDR_IRQ_FLAG: reg_rdata_o <= irq_flag_bits;
        ADDR_CHIP_STATUS: begin
          reg_rdata_o[ST_INT] <= irq_o;
          reg_rdata_o[ST_LATE_COL] <= late_collision_flag;
          reg_rdata_o[ST_TX_ABORT] <= tx_abort_flag;
          reg_rdata_o[ST_CLK_READY] <= 1'b1;
        end
        ADDR_MAIN_CONTROL: begin
          reg_rdata_o <= main_other;
          reg_rdata_o[MC_TX_REQUEST] <= tx_request;
          reg_rdata_o[MC_DMA_KICKOFF] <= dma_kickoff;
        end
        ADDR_TX_START_LOW: reg_rdata_o <= tx_start_pointer[7:0];
        ADDR_TX_START_HIGH: reg_rdata_o <= {3'h0, tx_start_pointer[12:8]};
        ADDR_TX_END_LOW: reg_rdata_o <= tx_end_pointer[7:0];
        ADDR_TX_END_HIGH: reg_rdata_o <= {3'h0, tx_end_pointer[12:8]};
        default: begin
          if (reg_addr_i >= ADDR_MAC_FLOW && reg_addr_i <= ADDR_MAX_LEN_HIGH)
            reg_rdata_o <= mac_cfg[reg_addr_i];
        end
      endcase
    end
  end

  // Status bits sampled while the frame is in flight
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ev_defer_once <= 1'b0;
      ev_defer_excess <= 1'b0;
      ev_backpressure <= 1'b0;
      coll_cnt <= 4'h0;
    end else if (ce_i) begin
      if (state == S_ARB) begin
        ev_defer_once <= 1'b0;
        ev_defer_excess <= 1'b0;
        ev_backpressure <= 1'b0;
      end else if (busy) begin
        ev_defer_once <= ev_defer_once | defer_once_i;
        ev_defer_excess <= ev_defer_excess | defer_excess_i;
        ev_backpressure <= ev_backpressure | backpressure_i;
        coll_cnt <= coll_count_i;
      end
    end
  end

  // Little-endian status vector
  always_comb begin
    stat_vec = 56'h0;
    stat_vec[15:0] = pos;
    stat_vec[19:16] = aborted ? 4'h0 : coll_cnt;
    stat_vec[20] = !aborted && !crc_append && (crc != CRC_RESIDUE);
    stat_vec[21] = mac_cfg[ADDR_FRAME_CFG][FC_LEN_CHECK]
                   && (type_field <= LEN_MAX)
                   && (payload_len != type_field);
    stat_vec[22] = type_field > LEN_MAX;
    stat_vec[23] = !aborted;
    stat_vec[24] = mcast;
    stat_vec[25] = bcast;
    stat_vec[26] = ev_defer_once && !ev_defer_excess;
    stat_vec[27] = ev_defer_excess;
    stat_vec[28] = excess;
    stat_vec[29] = late;
    stat_vec[30] = giant;
    stat_vec[47:32] = pos;
    stat_vec[48] = type_field == TYPE_CTRL;
    stat_vec[49] = (type_field == TYPE_CTRL) && (opcode == OP_PAUSE);
    stat_vec[50] = ev_backpressure;
    stat_vec[51] = type_field == TYPE_VLAN;
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state <= S_IDLE;
      mem_rd_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= PTR_RST;
      mem_wdata_o <= REG_RST;
      {pp_ctl, pos, type_field, opcode, crc} <= '0;
      {rd_addr, fcs_idx, stat_idx, hand_word, req_tgl} <= '0;
      {first, in_fcs, bcast, mcast, aborted, late, excess, giant} <= '0;
      tx_abort_flag <= 1'b0;
      late_collision_flag <= 1'b0;
    end else if (ce_i) begin
      mem_rd_o <= 1'b0;
      mem_we_o <= 1'b0;
      unique case (state)
        S_IDLE: if (tx_request) state <= S_ARB;
        S_ARB: begin
          {pos, type_field, opcode, fcs_idx, stat_idx} <= '0;
          {in_fcs, bcast, mcast, late, excess, giant} <= '0;
          {tx_abort_flag, late_collision_flag} <= '0;
          crc <= CRC_INIT;
          first <= 1'b1;
          rd_addr <= tx_start_pointer;
          aborted <= !tx_request;
          if (!tx_request) state <= S_STAT;
          else if (!dma_running && !dma_start_o) state <= S_RD;
        end
        S_RD: begin
          if (abort_now || giant_hit) begin
            {aborted, late, excess, giant} <=
              {1'b1, coll_late_i, coll_excess_i, giant_hit};
            state <= S_TERM;
          end else begin
            mem_rd_o <= 1'b1;
            mem_addr_o <= rd_addr;
            state <= S_LAT;
          end
        end
        S_LAT: state <= S_CAP;
        S_CAP: begin
          rd_addr <= 13'(rd_addr + 13'h1);
          if (first) begin
            pp_ctl <= mem_rdata_i;
            first <= 1'b0;
            state <= S_RD;
          end else begin
            crc <= crc_next;
            if (pos == 16'h0000) begin
              mcast <= mem_rdata_i[0];
              bcast <= &mem_rdata_i;
            end else if (pos <= POS_DA_LAST) begin
              bcast <= bcast & (&mem_rdata_i);
            end
            if (pos == POS_TYPE_HI) type_field[15:8] <= mem_rdata_i;
            if (pos == POS_TYPE_LO) type_field[7:0] <= mem_rdata_i;
            if (pos == POS_OP_HI) opcode[15:8] <= mem_rdata_i;
            if (pos == POS_OP_LO) opcode[7:0] <= mem_rdata_i;
            hand_word <= {1'b0, (rd_addr == tx_end_pointer) && !crc_append,
                          mem_rdata_i};
            req_tgl <= !req_tgl;
            state <= S_SEND;
          end
        end
        S_SEND: begin
          if (ack_core == req_tgl) begin
            if (!hand_word[9]) pos <= 16'(pos + 16'h1);
            if (hand_word[8]) state <= S_STAT;
            else if (in_fcs) begin
              fcs_idx <= 2'(fcs_idx + 2'h1);
              state <= S_FCS;
            end else if (13'(rd_addr - 13'h1) == tx_end_pointer) begin
              in_fcs <= 1'b1;
              state <= S_FCS;
            end else state <= S_RD;
          end
        end
        S_FCS: begin
          if (abort_now) begin
            {aborted, late, excess} <= {1'b1, coll_late_i, coll_excess_i};
            state <= S_TERM;
          end else begin
            hand_word <= {1'b0, fcs_idx == FCS_LAST,
                          ~crc[8 * fcs_idx +: 8]};
            req_tgl <= !req_tgl;
            state <= S_SEND;
          end
        end
        S_TERM: begin
          hand_word <= {2'b11, 8'h00};
          req_tgl <= !req_tgl;
          state <= S_SEND;
        end
        S_STAT: begin
          mem_we_o <= 1'b1;
          mem_addr_o <= 13'(tx_end_pointer + 13'h1 + {10'h000, stat_idx});
          mem_wdata_o <= stat_vec[8 * stat_idx +: 8];
          stat_idx <= 3'(stat_idx + 3'h1);
          if (stat_idx == STAT_LAST) state <= S_END;
        end
        S_END: begin
          tx_abort_flag <= aborted;
          late_collision_flag <= late;
          state <= S_IDLE;
        end
      endcase
    end
  end

  // Toggle handshake; word held until the acknowledge returns
  sync_bit u_ack_sync (
    .clk_i(core_clk_i),
    .rst_i(srst_i),
    .en_i(ce_i),
    .d_i(ack_tgl),
    .q_o(ack_core)
  );
  sync_bit u_rst_sync (
    .clk_i(link_clk_i),
    .rst_i(1'b0),
    .en_i(1'b1),
    .d_i(srst_i),
    .q_o(link_rst)
  );
  sync_bit u_req_sync (
    .clk_i(link_clk_i),
    .rst_i(link_rst),
    .en_i(1'b1),
    .d_i(req_tgl),
    .q_o(req_link)
  );

  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      ack_tgl <= 1'b0;
      tx_byte_o <= REG_RST;
      tx_strobe_o <= 1'b0;
      tx_en_o <= 1'b0;
      end_pending <= 1'b0;
    end else begin
      tx_strobe_o <= 1'b0;
      if (end_pending) begin
        tx_en_o <= 1'b0;
        end_pending <= 1'b0;
      end
      if (req_link != ack_tgl) begin
        ack_tgl <= req_link;
        end_pending <= hand_word[8];
        if (hand_word[9]) tx_en_o <= 1'b0;
        else begin
          tx_byte_o <= hand_word[7:0];
          tx_strobe_o <= 1'b1;
          tx_en_o <= 1'b1;
        end
      end
    end
  end

  sequence s_req_seen;
    state == S_IDLE && tx_request && !dma_running && !dma_start_o && ce_i;
  endsequence
  // Host may still cancel in arbitration; only a kept request must fetch
  sequence s_req_kept;
    s_req_seen ##1 (tx_request && ce_i)
      ##1 (tx_request && ce_i && !coll_late_i && !coll_excess_i);
  endsequence
  sequence s_arb_to_read;
    state == S_ARB
      ##1 (state == S_RD && ce_i && tx_request && !coll_late_i
           && !coll_excess_i);
  endsequence

  property p_start;
    @(posedge core_clk_i) disable iff (srst_i) s_req_kept |=> mem_rd_o;
  endproperty
  a_start: assert property (p_start)
    else $error("transmit did not fetch after request");
  property p_ctl_first;
    @(posedge core_clk_i) disable iff (srst_i)
      s_arb_to_read |=> (mem_rd_o && mem_addr_o == tx_start_pointer);
  endproperty
  a_ctl_first: assert property (p_ctl_first)
    else $error("first fetch not at start pointer");
  property p_no_read_in_dma;
    @(posedge core_clk_i) disable iff (srst_i) mem_rd_o |-> !dma_running;
  endproperty
  a_no_read_in_dma: assert property (p_no_read_in_dma)
    else $error("frame fetch during DMA");
  property p_dma_gate;
    @(posedge core_clk_i) disable iff (srst_i)
      dma_start_o |-> !$past(tx_request);
  endproperty
  a_dma_gate: assert property (p_dma_gate)
    else $error("DMA started while request set");
  property p_done_flags;
    @(posedge core_clk_i) disable iff (srst_i)
      (tx_fin && !wr_main && !wr_flag) |=>
        (!tx_request && irq_flag_bits[IF_TX_DONE]);
  endproperty
  a_done_flags: assert property (p_done_flags)
    else $error("end of frame did not clear request or set flag");
  property p_stat_addr;
    @(posedge core_clk_i) disable iff (srst_i)
      mem_we_o |-> (13'(mem_addr_o - tx_end_pointer) >= 13'h0001
                    && 13'(mem_addr_o - tx_end_pointer) <= 13'h0007);
  endproperty
  a_stat_addr: assert property (p_stat_addr)
    else $error("status write outside vector area");
  property p_stat_top_zero;
    @(posedge core_clk_i) disable iff (srst_i)
      (mem_we_o && 13'(mem_addr_o - tx_end_pointer) == 13'h0007)
        |-> (mem_wdata_o[7:4] == 4'h0 && $past(state) == S_STAT);
  endproperty
  a_stat_top_zero: assert property (p_stat_top_zero)
    else $error("status bits 55-52 not zero");
  property p_count_low_first;
    @(posedge core_clk_i) disable iff (srst_i)
      (mem_we_o && 13'(mem_addr_o - tx_end_pointer) == 13'h0001)
        |-> (mem_wdata_o == pos[7:0]) ##1 (mem_wdata_o == pos[15:8]);
  endproperty
  a_count_low_first: assert property (p_count_low_first)
    else $error("byte count not stored low byte first");
  property p_ptr_stable;
    @(posedge core_clk_i) disable iff (srst_i)
      (state != S_IDLE && !wr_en) |=>
        ($stable(tx_start_pointer) && $stable(tx_end_pointer));
  endproperty
  a_ptr_stable: assert property (p_ptr_stable)
    else $error("pointer changed by transmit logic");
  property p_cancel;
    @(posedge core_clk_i) disable iff (srst_i)
      (busy && state != S_ARB && !tx_request) |-> ##[1:600] state == S_END;
  endproperty
  a_cancel: assert property (p_cancel)
    else $error("cancelled frame not ended in time");
  property p_link_strobe;
    @(posedge link_clk_i) disable iff (link_rst) tx_strobe_o |-> tx_en_o;
  endproperty
  a_link_strobe: assert property (p_link_strobe)
    else $error("byte strobe outside frame enable");
endmodule // packet_transmit_control

//--- include/tx_ctl_pkg.sv
package tx_ctl_pkg;

  // Register port offsets
  localparam logic [4:0] ADDR_IRQ_ENABLE = 5'h00;
  localparam logic [4:0] ADDR_IRQ_FLAG = 5'h01;
  localparam logic [4:0] ADDR_CHIP_STATUS = 5'h02;
  localparam logic [4:0] ADDR_MAIN_CONTROL = 5'h03;
  localparam logic [4:0] ADDR_TX_START_LOW = 5'h04;
  localparam logic [4:0] ADDR_TX_START_HIGH = 5'h05;
  localparam logic [4:0] ADDR_TX_END_LOW = 5'h06;
  localparam logic [4:0] ADDR_TX_END_HIGH = 5'h07;
  localparam logic [4:0] ADDR_MAC_FLOW = 5'h08;
  localparam logic [4:0] ADDR_FRAME_CFG = 5'h09;
  localparam logic [4:0] ADDR_MAX_LEN_LOW = 5'h10;
  localparam logic [4:0] ADDR_MAX_LEN_HIGH = 5'h11;

  // Field positions
  localparam int IE_GLOBAL = 7;
  localparam int IF_TX_DONE = 3;
  localparam int ST_INT = 7;
  localparam int ST_LATE_COL = 4;
  localparam int ST_TX_ABORT = 1;
  localparam int ST_CLK_READY = 0;
  localparam int MC_DMA_KICKOFF = 5;
  localparam int MC_TX_REQUEST = 3;
  localparam int FC_CRC_EN = 4;
  localparam int FC_HUGE_EN = 2;
  localparam int FC_LEN_CHECK = 1;
  localparam int PP_OVERRIDE = 0;
  localparam int PP_CRC_EN = 1;
  localparam int PP_HUGE_EN = 3;

  // Reset values and masks
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [12:0] PTR_RST = 13'h0000;
  localparam logic [7:0] MAX_LEN_LOW_RST = 8'hee;
  localparam logic [7:0] MAX_LEN_HIGH_RST = 8'h05;
  localparam logic [7:0] PTR_HIGH_MASK = 8'h1f;
  localparam logic [7:0] FLAG_MASK = 8'h7f;

  // Frame layout and status vector
  localparam logic [15:0] POS_DA_LAST = 16'h0005;
  localparam logic [15:0] POS_TYPE_HI = 16'h000c;
  localparam logic [15:0] POS_TYPE_LO = 16'h000d;
  localparam logic [15:0] POS_OP_HI = 16'h000e;
  localparam logic [15:0] POS_OP_LO = 16'h000f;
  localparam logic [15:0] HDR_FCS_LEN = 16'h0012;
  localparam logic [15:0] LEN_MAX = 16'h05dc;
  localparam logic [15:0] TYPE_VLAN = 16'h8100;
  localparam logic [15:0] TYPE_CTRL = 16'h8808;
  localparam logic [15:0] OP_PAUSE = 16'h0001;
  localparam logic [2:0] STAT_LAST = 3'h6;
  localparam logic [1:0] FCS_LAST = 2'h3;

  // Reflected CRC-32
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;

endpackage

//--- rtl/sync_bit.sv
`timescale 1ns/1ps
module sync_bit (
  // Clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  // Data
  input wire logic d_i,
  output logic q_o
);
  logic stage1;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage1 <= 1'b0;
      q_o <= 1'b0;
    end else if (en_i) begin
      stage1 <= d_i;
      q_o <= stage1;
    end
  end
endmodule // sync_bit

//--- rtl/crc32_step.sv
`timescale 1ns/1ps
module crc32_step (
  // Running value and byte in
  input wire logic [31:0] crc_i,
  input wire logic [7:0] data_i,
  // Updated value
  output logic [31:0] crc_o
);
  import tx_ctl_pkg::*;

  always_comb begin
    logic [31:0] c;
    c = crc_i ^ {24'h000000, data_i};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    crc_o = c;
  end
endmodule // crc32_step

//--- sim/buf_mem_model.sv
`timescale 1ns/1ps
module buf_mem_model (
  // Memory port
  input wire logic clk_i,
  input wire logic rd_i,
  input wire logic we_i,
  input wire logic [12:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [8192];
  initial rdata_o = 8'h00;
  // Idle data flips so a late sample cannot pass
  always @(posedge clk_i) begin
    if (rd_i) rdata_o <= mem[addr_i];
    else rdata_o <= ~rdata_o;
    if (we_i) mem[addr_i] <= wdata_i;
  end
endmodule // buf_mem_model

//--- sim/packet_transmit_control_tb.sv
`timescale 1ns/1ps
module packet_transmit_control_tb;
  import tx_ctl_pkg::*;
  logic core_clk_i = 0, link_clk_i = 0, srst_i = 1, ce_i = 1;
  logic reg_wr_i = 0, dma_done_i = 0, coll_late_i = 0, coll_excess_i = 0;
  logic defer_excess_i = 0, defer_once_i = 0, backpressure_i = 0;
  logic [3:0] coll_count_i = 0;
  logic [4:0] reg_addr_i = 0;
  logic [7:0] reg_wdata_i = 0, reg_rdata_o, mem_rdata_i, tx_byte_o, rd_v;
  logic mem_rd_o, mem_we_o, dma_start_o, irq_o, tx_en_o, tx_strobe_o;
  logic [12:0] mem_addr_o, tx_start, tx_end;
  logic [7:0] mem_wdata_o, sent[$], frame[$], sv [7];
  int errors = 0, tests_run = 0, cycles = 0, rd_seen = 0, dma_seen = 0;
  always #2 core_clk_i = ~core_clk_i;
  always #80 link_clk_i = ~link_clk_i;
  packet_transmit_control i_dut (.core_clk_i(core_clk_i),
    .link_clk_i(link_clk_i), .srst_i(srst_i), .ce_i(ce_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .mem_rd_o(mem_rd_o), .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_rdata_i(mem_rdata_i), .dma_start_o(dma_start_o),
    .dma_done_i(dma_done_i), .coll_late_i(coll_late_i),
    .coll_excess_i(coll_excess_i), .defer_excess_i(defer_excess_i),
    .defer_once_i(defer_once_i), .backpressure_i(backpressure_i),
    .coll_count_i(coll_count_i), .irq_o(irq_o), .tx_en_o(tx_en_o),
    .tx_strobe_o(tx_strobe_o), .tx_byte_o(tx_byte_o));
  buf_mem_model i_mem (.clk_i(core_clk_i), .rd_i(mem_rd_o),
    .we_i(mem_we_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
    .rdata_o(mem_rdata_i));
  always @(posedge link_clk_i) begin
    if (tx_strobe_o === 1'b1) sent.push_back(tx_byte_o);
  end
  // Three frames need well under a third of this
  always @(posedge core_clk_i) begin
    cycles++;
    if (mem_rd_o === 1'b1) rd_seen++;
    if (dma_start_o === 1'b1) dma_seen++;
    if (cycles == 40000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [4:0] a, logic [7:0] d);
    @(posedge core_clk_i) #1;
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1;
    @(posedge core_clk_i) #1;
    reg_wr_i = 0;
  endtask
  task automatic rd(logic [4:0] a);
    @(posedge core_clk_i) #1;
    reg_addr_i = a;
    repeat (2) @(posedge core_clk_i);
    #1 rd_v = reg_rdata_o;
  endtask
  function automatic logic [31:0] fcs_of(int last);
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = 1; i <= last; i++) begin
      c = c ^ {24'h000000, frame[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction
  task automatic run_frame(bit cancel, bit with_dma);
    int n, m;
    bit own;
    logic [31:0] fcs;
    own = !cancel && !with_dma;
    frame = {};
    sent = {};
    n = 14 + $urandom_range(1, 6) + (own ? 4 : 0);
    m = own ? n : n + 4;
    tx_start = 13'($urandom_range(16, 2000) * 2);
    tx_end = tx_start + 13'(n);
    frame.push_back(own ? 8'h01 : 8'h03);
    for (int i = 1; i <= n; i++) begin
      frame.push_back(i <= 6 ? 8'hff : i == 13 ? 8'h81 :
        i == 14 ? 8'h00 : 8'($urandom));
    end
    // Host supplies its own check sequence in the last four bytes
    if (own) begin
      fcs = fcs_of(n - 4);
      for (int i = 0; i < 4; i++) frame[n - 3 + i] = fcs[8 * i +: 8];
    end
    foreach (frame[i]) i_mem.mem[tx_start + 13'(i)] = frame[i];
    wr(ADDR_TX_START_LOW, tx_start[7:0]);
    wr(ADDR_TX_START_HIGH, {3'h0, tx_start[12:8]});
    wr(ADDR_TX_END_LOW, tx_end[7:0]);
    wr(ADDR_TX_END_HIGH, {3'h0, tx_end[12:8]});
    wr(ADDR_IRQ_FLAG, 8'h00);
    wr(ADDR_IRQ_ENABLE, 8'h88);
    defer_once_i = 1'($urandom);
    backpressure_i = 1'($urandom);
    coll_count_i = 4'($urandom);
    if (with_dma) begin
      wr(ADDR_MAIN_CONTROL, 8'h20);
      repeat (3) @(posedge core_clk_i);
      chk("dma start", 1, 16'(dma_seen));
      rd_seen = 0;
      wr(ADDR_MAIN_CONTROL, 8'h28);
      repeat (40) @(posedge core_clk_i);
      chk("read during dma", 0, 16'(rd_seen));
      #1 dma_done_i = 1;
      @(posedge core_clk_i) #1 dma_done_i = 0;
    end else wr(ADDR_MAIN_CONTROL, own ? 8'h28 : 8'h08);
    if (cancel) wr(ADDR_MAIN_CONTROL, 8'h00);
    rd_v = 0;
    while (rd_v[IF_TX_DONE] !== 1'b1) rd(ADDR_IRQ_FLAG);
    // Last link byte and enable drop land up to a link cycle later
    repeat (2) @(posedge link_clk_i);
    #1 chk("irq", 1, irq_o);
    chk("link idle", 0, tx_en_o);
    rd(ADDR_MAIN_CONTROL);
    chk("request", 0, rd_v[MC_TX_REQUEST]);
    rd(ADDR_CHIP_STATUS);
    chk("abort", cancel, rd_v[ST_TX_ABORT]);
    rd(ADDR_TX_START_LOW);
    chk("start low", tx_start[7:0], rd_v);
    rd(ADDR_TX_END_HIGH);
    chk("end high", tx_end[12:8], rd_v);
    for (int i = 0; i < 7; i++) sv[i] = i_mem.mem[tx_end + 13'(i + 1)];
    chk("done", !cancel, sv[2][7]);
    chk("zero bits", 0, {sv[6][7:4], sv[3][7]});
    if (!cancel) begin
      chk("byte count", 16'(m), {sv[1], sv[0]});
      chk("wire total", 16'(m), {sv[5], sv[4]});
      chk("status2", {4'b1100, coll_count_i}, sv[2]);
      chk("status3", {5'h0, defer_once_i, 2'b11}, sv[3]);
      chk("status6", {4'h0, 1'b1, backpressure_i, 2'b0}, sv[6]);
      chk("link count", 16'(m), 16'(sent.size()));
      for (int i = 1; i <= n && i <= sent.size(); i++) begin
        chk("link byte", frame[i], sent[i - 1]);
      end
      fcs = fcs_of(m - 4);
      for (int i = 0; i < 4 && m - 4 + i < sent.size(); i++) begin
        chk("fcs byte", fcs[8 * i +: 8], sent[m - 4 + i]);
      end
    end else chk("cancel sent", 0, 16'(sent.size()));
    // DMA asked for during the frame may only start once it ends
    if (own) begin
      chk("dma after frame", 2, 16'(dma_seen));
      #1 dma_done_i = 1;
      @(posedge core_clk_i) #1 dma_done_i = 0;
    end
    $display("frame done cancel=%0d length=%0d", cancel, n);
  endtask
  initial begin
    void'($urandom(32'h0038));
    repeat (6) @(posedge link_clk_i);
    #1 srst_i = 0;
    run_frame(0, 1);
    run_frame(0, 0);
    run_frame(1, 0);
    report_and_stop();
  end
endmodule // packet_transmit_control_tb
